// ### common/port3_gpio_consts.svh
// Register indices, field positions, reset values and bus codes for the port 3 pin block.
// Assumes it is included by bare name by the package and by the design file.
`ifndef PORT3_GPIO_CONSTS_SVH
`define PORT3_GPIO_CONSTS_SVH

// Bus address width; byte address is four times the register index.
`define P3_ADDR_W            18
`define P3_INDEX_W           16

// Register indices.
`define P3_IDX_OUTPUT_LATCH  16'hFFD6
`define P3_IDX_DIRECTION     16'hFFE6
`define P3_IDX_PULLUP        16'hFFEE
`define P3_IDX_FUNCTION_SEL  16'hFFFD
`define P3_IDX_AUX_PIN_MODE  16'hFFFF
`define P3_IDX_AUX_CONTROL   16'hFFC0

// Reset values.
`define P3_RST_PORT          3'h0
`define P3_RST_AUX_PIN_MODE  8'hF8

// Field positions.
`define P3_FS_DATAOUT        2
`define P3_FS_DATAIN         1
`define P3_FS_CLOCKPIN       0
`define P3_AUX_TXD           2
`define P3_AUX_OPENDRAIN     0
`define P3_CTL_P22_DIR       0
`define P3_CTL_CLK_SOURCE    1
`define P3_CTL_P22_LATCH     2
`define P3_CTL_P22_LEVEL     3

// Fixed read patterns.
`define P3_DIRECTION_READ    8'hFF
`define P3_AUX_RSVD_HIGH     5'h1F

// Bus response codes.
`define P3_RESP_OKAY         2'h0
`define P3_RESP_SLVERR       2'h2

`endif

// ### common/port3_gpio_pkg.sv
// Types shared by the port 3 pin block and its bench.
// Assumes the constants header sits beside it on the include path.
`include "port3_gpio_consts.svh"

package port3_gpio_pkg;
   typedef logic [2:0]              port_bits_type;
   typedef logic [7:0]              reg_byte_type;
   typedef logic [`P3_ADDR_W-1:0]   bus_addr_type;
   typedef logic [`P3_INDEX_W-1:0]  reg_index_type;
   typedef logic [1:0]              bus_resp_type;
endpackage

// ### logic/port3_gpio.sv
// Three-pin general purpose port with serial channel pin sharing, plus the
// transmit-data pin of port 2, reached over an AXI4-Lite register slave.
// Assumes one clock, a synchronous active-high reset, pad inputs already
// synchronous to the clock, and pads that resolve out/enable pairs outside.
`timescale 1ns/1ps
`include "port3_gpio_consts.svh"

// Overview of operation
// - Reading port data returns the latch bit for each pin set as output.
// - Reading port data returns the pin level for each pin set as input.
// - Direction bit 1 drives latch value onto pin; 0 makes it an input.
// - Direction and latch drive the pin only in general I/O function; read-back and the pull-up gate use them in any function.
// - Direction register is write-only and always reads as all ones.
// - Data, pull-up and function registers: bits 7 to 3 read zero, ignore writes.
// - With direction 0, pull-up bit 1 turns pull-up on, 0 turns it off.
// - Function bit 2 gives pin 2 to general I/O or serial data output.
// - Function bit 1 gives pin 1 to general I/O or serial data input.
// - Function bit 0 gives pin 0 to general I/O or serial clock pin.
// - Aux mode bit 2 gives port-2 pin 2 to general I/O or transmit output.
// - Unselected transmit pin follows its own direction bit: 0 input, 1 output.
// - Aux mode bit 0 makes the data-out pin push-pull (0) or open-drain (1).
// - Aux mode bits 7 to 3 read one, bit 1 reads zero; writes ignored.
// - Reset clears data, direction, pull-up and function registers; pins are inputs.
// - Reset loads the aux mode register with its fixed initial pattern.
// - Selected clock pin drives clock out when source bit 0, receives when 1.
// - Pins float in reset and standby, pull-ups stay in standby only (reset clears them); sleep and watch hold state.
module port3_gpio (
   input  wire logic                          CLOCK,
   input  wire logic                          SYS_RST,
   // AXI4-Lite slave.
   input  wire logic                          S_AXI_AWVALID,
   output logic                               S_AXI_AWREADY,
   input  wire port3_gpio_pkg::bus_addr_type  S_AXI_AWADDR,
   input  wire logic [2:0]                    S_AXI_AWPROT,
   input  wire logic                          S_AXI_WVALID,
   output logic                               S_AXI_WREADY,
   input  wire logic [31:0]                   S_AXI_WDATA,
   input  wire logic [3:0]                    S_AXI_WSTRB,
   output logic                               S_AXI_BVALID,
   input  wire logic                          S_AXI_BREADY,
   output port3_gpio_pkg::bus_resp_type       S_AXI_BRESP,
   input  wire logic                          S_AXI_ARVALID,
   output logic                               S_AXI_ARREADY,
   input  wire port3_gpio_pkg::bus_addr_type  S_AXI_ARADDR,
   input  wire logic [2:0]                    S_AXI_ARPROT,
   output logic                               S_AXI_RVALID,
   input  wire logic                          S_AXI_RREADY,
   output logic [31:0]                        S_AXI_RDATA,
   output port3_gpio_pkg::bus_resp_type       S_AXI_RRESP,
   // Power mode inputs from the system controller.
   input  wire logic                          STANDBY,
   input  wire logic                          HOLD_STATE,
   // Port 3 pads.
   input  wire port3_gpio_pkg::port_bits_type PORT_PIN_IN,
   output port3_gpio_pkg::port_bits_type      PORT_PIN_OUT,
   output port3_gpio_pkg::port_bits_type      PORT_PIN_OE_N,
   output port3_gpio_pkg::port_bits_type      PORT_PIN_PULLUP,
   // Port 2 pin 2 pad.
   input  wire logic                          P2_PIN2_IN,
   output logic                               P2_PIN2_OUT,
   output logic                               P2_PIN2_OE_N,
   // Serial channel side.
   input  wire logic                          SERIAL_DATAOUT,
   output logic                               SERIAL_DATAIN,
   input  wire logic                          SERIAL_CLOCK_OUT,
   output logic                               SERIAL_CLOCK_IN,
   input  wire logic                          TRANSMIT_DATA
);

   // Stored register bits; only the implemented bits are kept as flops.
   port3_gpio_pkg::port_bits_type port_output_latch;
   port3_gpio_pkg::port_bits_type port_direction;
   port3_gpio_pkg::port_bits_type port_pullup_enable;
   port3_gpio_pkg::port_bits_type port_function_select;
   logic                          transmit_select;
   logic                          dataout_opendrain_select;
   logic                          port2_pin2_direction;
   logic                          port2_pin2_latch;
   logic                          serial_clock_source;

   // Bus slave state.
   logic                          aw_held;
   logic                          w_held;
   port3_gpio_pkg::reg_index_type write_index;
   port3_gpio_pkg::reg_byte_type  write_byte;
   logic                          write_lane;
   logic                          do_write;
   logic                          write_hit;
   port3_gpio_pkg::reg_index_type read_index;
   port3_gpio_pkg::reg_byte_type  read_byte;
   logic                          read_hit;

   // Next pin values, worked out combinationally and then registered.
   port3_gpio_pkg::port_bits_type next_pin_out;
   port3_gpio_pkg::port_bits_type next_pin_drive;
   port3_gpio_pkg::port_bits_type next_pin_pullup;
   logic                          next_p22_out;
   logic                          next_p22_drive;
   logic                          serial_dataout_select;
   logic                          serial_datain_select;
   logic                          serial_clockpin_select;

   // Named so reset can pick its bits.
   localparam logic [7:0]         aux_reset = `P3_RST_AUX_PIN_MODE;

   // One function select per shared pin.
   assign serial_dataout_select  = port_function_select[`P3_FS_DATAOUT];
   assign serial_datain_select   = port_function_select[`P3_FS_DATAIN];
   assign serial_clockpin_select = port_function_select[`P3_FS_CLOCKPIN];

   // Write address channel: accept one address, then wait for the response to go.
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         aw_held       <= 1'b0;
         write_index   <= '0;
         S_AXI_AWREADY <= 1'b1;
      end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
         aw_held       <= 1'b1;
         write_index   <= S_AXI_AWADDR[`P3_ADDR_W-1:2];
         S_AXI_AWREADY <= 1'b0;
      end else if (do_write) begin
         aw_held       <= 1'b0;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
         S_AXI_AWREADY <= 1'b1;
      end
   end

   // Write data channel: only the low byte lane carries register data.
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         w_held       <= 1'b0;
         write_byte   <= '0;
         write_lane   <= 1'b0;
         S_AXI_WREADY <= 1'b1;
      end else if (S_AXI_WVALID && S_AXI_WREADY) begin
         w_held       <= 1'b1;
         write_byte   <= S_AXI_WDATA[7:0];
         write_lane   <= S_AXI_WSTRB[0];
         S_AXI_WREADY <= 1'b0;
      end else if (do_write) begin
         w_held       <= 1'b0;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
         S_AXI_WREADY <= 1'b1;
      end
   end

   // A write happens once both halves are held; the ready flags stay low until
   // the response is taken, which keeps a single write in flight.
   assign do_write  = aw_held && w_held && !S_AXI_BVALID;
   assign write_hit = (write_index == `P3_IDX_OUTPUT_LATCH) ||
                      (write_index == `P3_IDX_DIRECTION)    ||
                      (write_index == `P3_IDX_PULLUP)       ||
                      (write_index == `P3_IDX_FUNCTION_SEL) ||
                      (write_index == `P3_IDX_AUX_PIN_MODE) ||
                      (write_index == `P3_IDX_AUX_CONTROL);

   // Write response: unmapped indices answer with a slave error and change nothing.
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP  <= `P3_RESP_OKAY;
      end else if (do_write) begin
         S_AXI_BVALID <= 1'b1;
         S_AXI_BRESP  <= write_hit ? `P3_RESP_OKAY : `P3_RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
         S_AXI_BVALID <= 1'b0;
      end
   end

   // Port 3 registers; a write with the low strobe clear leaves them alone.
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         port_output_latch    <= `P3_RST_PORT;
         port_direction       <= `P3_RST_PORT;
         port_pullup_enable   <= `P3_RST_PORT;
         port_function_select <= `P3_RST_PORT;
      end else if (do_write && write_lane) begin
         // Upper bits are dropped here so reserved bits can never be set.
         case (write_index)
            `P3_IDX_OUTPUT_LATCH: port_output_latch    <= write_byte[2:0];
            `P3_IDX_DIRECTION:    port_direction       <= write_byte[2:0];
            `P3_IDX_PULLUP:       port_pullup_enable   <= write_byte[2:0];
            `P3_IDX_FUNCTION_SEL: port_function_select <= write_byte[2:0];
            default: begin
            end
         endcase
      end
   end

   // Auxiliary mode bits and the extra control register.
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         transmit_select          <= aux_reset[`P3_AUX_TXD];
         dataout_opendrain_select <= aux_reset[`P3_AUX_OPENDRAIN];
         port2_pin2_direction     <= 1'b0;
         port2_pin2_latch         <= 1'b0;
         serial_clock_source      <= 1'b0;
      end else if (do_write && write_lane) begin
         if (write_index == `P3_IDX_AUX_PIN_MODE) begin
            // Only bits 2 and 0 are stored; the rest are fixed on read.
            transmit_select          <= write_byte[`P3_AUX_TXD];
            dataout_opendrain_select <= write_byte[`P3_AUX_OPENDRAIN];
         end
         if (write_index == `P3_IDX_AUX_CONTROL) begin
            port2_pin2_direction <= write_byte[`P3_CTL_P22_DIR];
            port2_pin2_latch     <= write_byte[`P3_CTL_P22_LATCH];
            serial_clock_source  <= write_byte[`P3_CTL_CLK_SOURCE];
         end
      end
   end

   // Read mux, sampled at the address handshake so the answer reflects that edge.
   assign read_hit = (read_index == `P3_IDX_OUTPUT_LATCH) ||
                     (read_index == `P3_IDX_DIRECTION)    ||
                     (read_index == `P3_IDX_PULLUP)       ||
                     (read_index == `P3_IDX_FUNCTION_SEL) ||
                     (read_index == `P3_IDX_AUX_PIN_MODE) ||
                     (read_index == `P3_IDX_AUX_CONTROL);
   assign read_index = S_AXI_ARADDR[`P3_ADDR_W-1:2];

   // Read byte for the addressed register.
   always_comb begin
      read_byte = 8'h00;
      case (read_index)
         `P3_IDX_OUTPUT_LATCH: begin
            // Outputs read back the latch, inputs read the pad.
            read_byte = {5'h00, (port_direction & port_output_latch) |
                                (~port_direction & PORT_PIN_IN)};
         end
         `P3_IDX_DIRECTION: begin
            read_byte = `P3_DIRECTION_READ;
         end
         `P3_IDX_PULLUP: begin
            read_byte = {5'h00, port_pullup_enable};
         end
         `P3_IDX_FUNCTION_SEL: begin
            read_byte = {5'h00, port_function_select};
         end
         `P3_IDX_AUX_PIN_MODE: begin
            read_byte = {`P3_AUX_RSVD_HIGH, transmit_select, 1'b0,
                         dataout_opendrain_select};
         end
         `P3_IDX_AUX_CONTROL: begin
            read_byte = {4'h0, P2_PIN2_IN, port2_pin2_latch, serial_clock_source,
                         port2_pin2_direction};
         end
         default: begin
            read_byte = 8'h00;
         end
      endcase
   end

   // Read channel: one read in flight, answered one edge after the address.
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         S_AXI_ARREADY <= 1'b1;
         S_AXI_RVALID  <= 1'b0;
         S_AXI_RDATA   <= 32'h00000000;
         S_AXI_RRESP   <= `P3_RESP_OKAY;
      end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID  <= 1'b1;
         S_AXI_RDATA   <= {24'h000000, read_byte};
         S_AXI_RRESP   <= read_hit ? `P3_RESP_OKAY : `P3_RESP_SLVERR;
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
         S_AXI_RVALID  <= 1'b0;
         S_AXI_ARREADY <= 1'b1;
      end
   end

   // Pin ownership. General I/O drives from the latch when the direction bit
   // is set; a serial function takes the pin over regardless of direction.
   always_comb begin
      next_pin_out   = port_output_latch;
      next_pin_drive = port_direction;
      // Pin 2: serial data output.
      if (serial_dataout_select) begin
         next_pin_out[2]   = SERIAL_DATAOUT;
         next_pin_drive[2] = 1'b1;
      end
      // Open-drain removes the high side, so a one lets the pin float.
      if (dataout_opendrain_select && next_pin_out[2]) begin
         next_pin_drive[2] = 1'b0;
      end
      // Pin 1: serial data input, never driven.
      if (serial_datain_select) begin
         next_pin_out[1]   = 1'b0;
         next_pin_drive[1] = 1'b0;
      end
      // Pin 0: serial clock, direction chosen by the channel's clock source.
      if (serial_clockpin_select) begin
         next_pin_out[0]   = SERIAL_CLOCK_OUT;
         next_pin_drive[0] = !serial_clock_source;
      end
   end

   // Port 2 pin 2: transmit output or plain I/O under its own direction bit.
   always_comb begin
      if (transmit_select) begin
         next_p22_out   = TRANSMIT_DATA;
         next_p22_drive = 1'b1;
      end else begin
         next_p22_out   = port2_pin2_latch;
         next_p22_drive = port2_pin2_direction;
      end
   end

   // Pull-ups: only a pin whose direction bit is clear may have one.
   assign next_pin_pullup = port_pullup_enable & ~port_direction;

   // Pad registers, one generate lane per pin. Reset and standby float the
   // driver; sleep and watch freeze every pad output where it stands. The
   // pull-up is left alone in standby so a pulled pin still sits high.
   genvar pin;
   generate
      for (pin = 0; pin < 3; pin = pin + 1) begin : g_pad
         always_ff @(posedge CLOCK) begin
            if (SYS_RST) begin
               PORT_PIN_OUT[pin]    <= 1'b0;
               PORT_PIN_OE_N[pin]   <= 1'b1;
               PORT_PIN_PULLUP[pin] <= 1'b0;
            end else if (HOLD_STATE) begin
               PORT_PIN_OUT[pin]    <= PORT_PIN_OUT[pin];
               PORT_PIN_OE_N[pin]   <= PORT_PIN_OE_N[pin];
               PORT_PIN_PULLUP[pin] <= PORT_PIN_PULLUP[pin];
            end else if (STANDBY) begin
               PORT_PIN_OUT[pin]    <= next_pin_out[pin];
               PORT_PIN_OE_N[pin]   <= 1'b1;
               PORT_PIN_PULLUP[pin] <= next_pin_pullup[pin];
            end else begin
               PORT_PIN_OUT[pin]    <= next_pin_out[pin];
               PORT_PIN_OE_N[pin]   <= !next_pin_drive[pin];
               PORT_PIN_PULLUP[pin] <= next_pin_pullup[pin];
            end
         end
      end
   endgenerate

   // Port 2 pin 2 pad, with the same power-mode treatment as port 3.
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         P2_PIN2_OUT  <= 1'b0;
         P2_PIN2_OE_N <= 1'b1;
      end else if (HOLD_STATE) begin
         P2_PIN2_OUT  <= P2_PIN2_OUT;
         P2_PIN2_OE_N <= P2_PIN2_OE_N;
      end else if (STANDBY) begin
         P2_PIN2_OUT  <= next_p22_out;
         P2_PIN2_OE_N <= 1'b1;
      end else begin
         P2_PIN2_OUT  <= next_p22_out;
         P2_PIN2_OE_N <= !next_p22_drive;
      end
   end

   // Serial inputs toward the channel. Idle data reads high and an unselected
   // clock reads low, so the channel sees no false edges while unrouted.
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         SERIAL_DATAIN   <= 1'b1;
         SERIAL_CLOCK_IN <= 1'b0;
      end else begin
         SERIAL_DATAIN   <= serial_datain_select ? PORT_PIN_IN[1] : 1'b1;
         SERIAL_CLOCK_IN <= (serial_clockpin_select && serial_clock_source) ?
                            PORT_PIN_IN[0] : 1'b0;
      end
   end

endmodule

// ### sim/port3_gpio_assertions.sv
// Concurrent checks on the bus handshakes and pad outputs of the port 3 block.
// Assumes the package is compiled first and one clock domain with a synchronous reset.
`timescale 1ns/1ps
module port3_gpio_assertions (
   input wire logic                          CLOCK,
   input wire logic                          SYS_RST,
   input wire logic                          S_AXI_AWREADY,
   input wire logic                          S_AXI_WREADY,
   input wire logic                          S_AXI_BVALID,
   input wire logic                          S_AXI_BREADY,
   input wire logic                          S_AXI_ARVALID,
   input wire logic                          S_AXI_ARREADY,
   input wire logic                          S_AXI_RVALID,
   input wire logic                          S_AXI_RREADY,
   input wire logic [31:0]                   S_AXI_RDATA,
   input wire logic                          STANDBY,
   input wire logic                          HOLD_STATE,
   input wire port3_gpio_pkg::port_bits_type PORT_PIN_OUT,
   input wire port3_gpio_pkg::port_bits_type PORT_PIN_OE_N,
   input wire port3_gpio_pkg::port_bits_type PORT_PIN_PULLUP
);
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (SYS_RST);
   // A taken read answers on the next edge with only the low byte used.
   property p_rd_answer; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && S_AXI_RDATA[31:8] == 24'h0; endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read answer late or wide");
   property p_rd_stand; S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA); endproperty
   a_rd_stand: assert property (p_rd_stand) else $error("read data dropped");
   property p_rd_one; S_AXI_RVALID |-> !S_AXI_ARREADY; endproperty
   a_rd_one: assert property (p_rd_one) else $error("second read taken");
   property p_b_stand; S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID; endproperty
   a_b_stand: assert property (p_b_stand) else $error("write response dropped");
   property p_b_done; S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID && S_AXI_AWREADY && S_AXI_WREADY; endproperty
   a_b_done: assert property (p_b_done) else $error("write not closed");
   // Standby floats every pad one edge later unless hold freezes them.
   property p_float; STANDBY && !HOLD_STATE |=> PORT_PIN_OE_N == 3'h7; endproperty
   a_float: assert property (p_float) else $error("pad driven in standby");
   property p_hold; HOLD_STATE |=> $stable(PORT_PIN_OE_N) && $stable(PORT_PIN_OUT) && $stable(PORT_PIN_PULLUP); endproperty
   a_hold: assert property (p_hold) else $error("pad changed while held");
   // The reset edge itself is checked, so this one is not disabled by reset.
   property p_rst; disable iff (1'b0) SYS_RST |=> PORT_PIN_OE_N == 3'h7 && PORT_PIN_PULLUP == 3'h0; endproperty
   a_rst: assert property (p_rst) else $error("pads not released by reset");
endmodule

bind port3_gpio port3_gpio_assertions chk (.*);

// ### sim/port3_gpio_pads.sv
// Board model of the three port 3 wires and the port 2 transmit wire.
// Assumes the bench may overdrive any port 3 wire to test read-back of the pad level.
`timescale 1ns/1ps
module port3_gpio_pads (
   input  wire logic       clk,
   input  wire logic [2:0] pin_out,
   input  wire logic [2:0] pin_oe_n,
   input  wire logic [2:0] pin_pullup,
   input  wire logic       p2_out,
   input  wire logic       p2_oe_n,
   input  wire logic [2:0] ext_val,
   input  wire logic [2:0] ext_en,
   output logic [2:0]      pin_in,
   output logic            p2_in
);
   logic [2:0] floating;
   // A released wire without pull-up toggles, so a stale level is never mistaken for data.
   initial floating = 3'h0;
   always @(posedge clk) floating <= ~floating;
   // An outside driver wins, so a driven pin can carry a level unlike its latch.
   always_comb begin
      for (int n = 0; n < 3; n++) begin
         if (ext_en[n]) pin_in[n] = ext_val[n];
         else if (!pin_oe_n[n]) pin_in[n] = pin_out[n];
         else pin_in[n] = pin_pullup[n] | floating[n];
      end
      p2_in = p2_oe_n ? floating[0] : p2_out;
   end
endmodule

// ### sim/port3_gpio_tb_top.sv
// Self-checking bench for the port 3 pin block over its register bus and pads.
// Assumes block, package, pad model and checker are compiled before this file.
`timescale 1ns/1ps
`include "port3_gpio_consts.svh"
module port3_gpio_tb_top;
   logic CLOCK = 1'b0, SYS_RST = 1'b1, STANDBY = 1'b0, HOLD_STATE = 1'b0;
   logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
   logic S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0, SERIAL_DATAOUT = 1'b0;
   logic SERIAL_CLOCK_OUT = 1'b0, TRANSMIT_DATA = 1'b0;
   logic [2:0] S_AXI_AWPROT = 3'h0, S_AXI_ARPROT = 3'h0, ext_val = 3'h1, ext_en = 3'h7;
   logic [3:0] S_AXI_WSTRB = 4'hF;
   logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA, d;
   port3_gpio_pkg::bus_addr_type S_AXI_AWADDR = '0, S_AXI_ARADDR = '0;
   logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
   logic P2_PIN2_IN, P2_PIN2_OUT, P2_PIN2_OE_N, SERIAL_DATAIN, SERIAL_CLOCK_IN;
   port3_gpio_pkg::bus_resp_type S_AXI_BRESP, S_AXI_RRESP;
   port3_gpio_pkg::port_bits_type PORT_PIN_IN, PORT_PIN_OUT, PORT_PIN_OE_N, PORT_PIN_PULLUP;
   int fails = 0, cmp_count = 0;

   port3_gpio dut (.*);
   port3_gpio_pads pads (.clk(CLOCK), .pin_out(PORT_PIN_OUT), .pin_oe_n(PORT_PIN_OE_N),
      .pin_pullup(PORT_PIN_PULLUP), .p2_out(P2_PIN2_OUT), .p2_oe_n(P2_PIN2_OE_N),
      .ext_val(ext_val), .ext_en(ext_en), .pin_in(PORT_PIN_IN), .p2_in(P2_PIN2_IN));

   // Free-running system clock.
   initial forever #12.5 CLOCK = ~CLOCK;

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Outputs are sampled at the falling edge, where the registered values have settled.
   task automatic wr(input logic [15:0] idx, input logic [7:0] v, input logic [1:0] er);
      logic ta, tw;
      @(posedge CLOCK);
      S_AXI_AWADDR <= {idx, 2'h0};
      S_AXI_WDATA <= {24'h0, v};
      S_AXI_AWVALID <= 1'b1;
      S_AXI_WVALID <= 1'b1;
      do begin
         @(negedge CLOCK);
         ta = S_AXI_AWVALID & S_AXI_AWREADY;
         tw = S_AXI_WVALID & S_AXI_WREADY;
         @(posedge CLOCK);
         if (ta) S_AXI_AWVALID <= 1'b0;
         if (tw) S_AXI_WVALID <= 1'b0;
      end while ((S_AXI_AWVALID & !ta) | (S_AXI_WVALID & !tw));
      do @(negedge CLOCK); while (!S_AXI_BVALID);
      chk(S_AXI_BRESP, er);
      @(posedge CLOCK) S_AXI_BREADY <= 1'b1;
      @(posedge CLOCK) S_AXI_BREADY <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] idx, input logic [1:0] er, output logic [31:0] v);
      @(posedge CLOCK);
      S_AXI_ARADDR <= {idx, 2'h0};
      S_AXI_ARVALID <= 1'b1;
      do @(negedge CLOCK); while (!S_AXI_ARREADY);
      @(posedge CLOCK);
      S_AXI_ARVALID <= 1'b0;
      do @(negedge CLOCK); while (!S_AXI_RVALID);
      v = S_AXI_RDATA;
      chk(S_AXI_RRESP, er);
      @(posedge CLOCK) S_AXI_RREADY <= 1'b1;
      @(posedge CLOCK) S_AXI_RREADY <= 1'b0;
   endtask
   task automatic rc(input logic [15:0] idx, input logic [31:0] exp);
      logic [31:0] v;
      rd(idx, `P3_RESP_OKAY, v);
      chk(v, exp);
   endtask
   // Pads lag their causes by one edge; three falling edges leave margin.
   task automatic settle;
      repeat (3) @(negedge CLOCK);
   endtask
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Watchdog: the sequence needs well under a thousand cycles.
   initial begin
      repeat (6000) @(posedge CLOCK);
      fails++;
      print_verdict();
   end

   initial begin
      repeat (12) @(posedge CLOCK);
      SYS_RST <= 1'b0;
      @(negedge CLOCK) chk(PORT_PIN_OE_N, 3'h7);
      rc(`P3_IDX_OUTPUT_LATCH, 32'h1);
      rc(`P3_IDX_DIRECTION, 32'hFF);
      rc(`P3_IDX_PULLUP, 32'h0);
      rc(`P3_IDX_FUNCTION_SEL, 32'h0);
      rc(`P3_IDX_AUX_PIN_MODE, 32'hF8);
      rd(16'h1234, `P3_RESP_SLVERR, d);
      chk(d, 32'h0);
      chk({SERIAL_DATAIN, PORT_PIN_PULLUP}, 4'h8);
      $display("test reset done");
      wr(`P3_IDX_OUTPUT_LATCH, 8'hFE, `P3_RESP_OKAY);
      wr(`P3_IDX_DIRECTION, 8'h05, `P3_RESP_OKAY);
      @(posedge CLOCK) S_AXI_WSTRB <= 4'h0;
      wr(`P3_IDX_OUTPUT_LATCH, 8'h00, `P3_RESP_OKAY);
      @(posedge CLOCK) S_AXI_WSTRB <= 4'hF;
      rc(`P3_IDX_OUTPUT_LATCH, 32'h04);
      wr(16'h1234, 8'h55, `P3_RESP_SLVERR);
      settle();
      chk({PORT_PIN_OE_N, PORT_PIN_OUT[2], PORT_PIN_OUT[0]}, 5'b01010);
      $display("test data done");
      wr(`P3_IDX_PULLUP, 8'hFF, `P3_RESP_OKAY);
      rc(`P3_IDX_PULLUP, 32'h07);
      settle();
      chk(PORT_PIN_PULLUP, 3'b010);
      wr(`P3_IDX_DIRECTION, 8'h00, `P3_RESP_OKAY);
      settle();
      chk({PORT_PIN_PULLUP, PORT_PIN_OE_N}, 6'h3F);
      $display("test pullup done");
      wr(`P3_IDX_DIRECTION, 8'h07, `P3_RESP_OKAY);
      wr(`P3_IDX_OUTPUT_LATCH, 8'h00, `P3_RESP_OKAY);
      @(posedge CLOCK);
      SERIAL_DATAOUT <= 1'b1;
      SERIAL_CLOCK_OUT <= 1'b1;
      ext_val <= 3'b000;
      wr(`P3_IDX_FUNCTION_SEL, 8'hFF, `P3_RESP_OKAY);
      rc(`P3_IDX_FUNCTION_SEL, 32'h07);
      settle();
      chk({PORT_PIN_OE_N, PORT_PIN_OUT[2], PORT_PIN_OUT[0]}, 5'b01011);
      chk(SERIAL_DATAIN, 1'b0);
      wr(`P3_IDX_AUX_CONTROL, 8'h02, `P3_RESP_OKAY);
      @(posedge CLOCK) ext_val <= 3'b001;
      settle();
      chk({PORT_PIN_OE_N[0], SERIAL_DATAIN, SERIAL_CLOCK_IN}, 3'b101);
      $display("test function done");
      wr(`P3_IDX_AUX_PIN_MODE, 8'h00, `P3_RESP_OKAY);
      rc(`P3_IDX_AUX_PIN_MODE, 32'hF8);
      @(posedge CLOCK) TRANSMIT_DATA <= 1'b1;
      wr(`P3_IDX_AUX_PIN_MODE, 8'hFF, `P3_RESP_OKAY);
      rc(`P3_IDX_AUX_PIN_MODE, 32'hFD);
      settle();
      chk({PORT_PIN_OE_N[2], P2_PIN2_OE_N, P2_PIN2_OUT}, 3'b101);
      @(posedge CLOCK);
      SERIAL_DATAOUT <= 1'b0;
      TRANSMIT_DATA <= 1'b0;
      settle();
      chk({PORT_PIN_OE_N[2], PORT_PIN_OUT[2], P2_PIN2_OUT}, 3'b000);
      wr(`P3_IDX_AUX_PIN_MODE, 8'h00, `P3_RESP_OKAY);
      wr(`P3_IDX_AUX_CONTROL, 8'h00, `P3_RESP_OKAY);
      settle();
      chk(P2_PIN2_OE_N, 1'b1);
      wr(`P3_IDX_AUX_CONTROL, 8'h05, `P3_RESP_OKAY);
      settle();
      chk({P2_PIN2_OE_N, P2_PIN2_OUT}, 2'b01);
      $display("test aux done");
      @(posedge CLOCK) STANDBY <= 1'b1;
      settle();
      chk(PORT_PIN_OE_N, 3'h7);
      @(posedge CLOCK) HOLD_STATE <= 1'b1;
      @(posedge CLOCK) STANDBY <= 1'b0;
      settle();
      chk(PORT_PIN_OE_N, 3'h7);
      @(posedge CLOCK) HOLD_STATE <= 1'b0;
      settle();
      chk(PORT_PIN_OE_N, 3'b010);
      $display("test power done");
      print_verdict();
   end
endmodule
